//--- src/rbc_bank_ctrl.sv
// Four-bank ROM/FLASH/SRAM chip select controller with Avalon-MM registers
// Behaviour
// - ARE=0: data sampled one clock after ready
// - ARE=1: data sampled three clocks after ready
// - Width code selects 8/16/32/64 bit bank
// - Independent chip select machine per bank
// - Burst mode select resets to zero
// - Flash write permit resets to zero
// - Bank 0 wait resets 010100, others zero
// - Bank 0 select delay resets 01
// - Bank 0 output enable delay resets 10
// - Bank 0 write strobe delay resets 01
// - Bank 0 port from strap, others zero
// - Bank 0 early release resets one
// - Bank 0 read hold resets 0100
// - Bank 0 write hold resets 0100
// - Bank 0 first burst wait resets 1011
// - Bank 0 throttle from strap, others zero
// - Async ready select resets to zero
// - Bank 0 width from strap, others 8-bit
// - Select asserts 0-3 clocks after address
// - Output enable 0-3 clocks after select
// - Throttle enable lets ready stretch access
// - Hold strobes read_hold_cycles after read
//
// Design decisions made here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module rbc_bank_ctrl (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [rbc_pkg::AV_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic strap_shared_port,
  input wire logic strap_throttle,
  input wire logic [1:0] strap_width,
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic [31:0] acc_addr,
  input wire logic [rbc_pkg::WIDE_W-1:0] acc_wdata,
  output logic acc_ready,
  output logic acc_done,
  output logic acc_error,
  output logic [rbc_pkg::WIDE_W-1:0] acc_rdata,
  output logic [31:0] mem_addr,
  output logic [rbc_pkg::NUM_BANKS-1:0] bank_sel_n,
  output logic [rbc_pkg::NUM_BANKS-1:0] bank_oe_n,
  output logic [rbc_pkg::NUM_BANKS-1:0] bank_we_n,
  output logic [rbc_pkg::NUM_BANKS-1:0] bank_read,
  output logic [rbc_pkg::NUM_BANKS-1:0] bank_write,
  input wire logic mem_ready,
  input wire logic [rbc_pkg::WIDE_W-1:0] wide_data_in,
  output logic [rbc_pkg::WIDE_W-1:0] wide_data_out,
  output logic wide_data_oe,
  input wire logic [rbc_pkg::NARROW_W-1:0] narrow_data_in,
  output logic [rbc_pkg::NARROW_W-1:0] narrow_data_out,
  output logic narrow_data_oe
);
  import rbc_pkg::*;

  // Lane mask for a bank width code
  function automatic logic [WIDE_W-1:0] lane_mask(input logic [1:0] code);
    logic [WIDE_W-1:0] m;
    m = '0;
    unique case (code)
      WIDTH_8: m = {{56{1'b0}}, {8{1'b1}}};
      WIDTH_16: m = {{48{1'b0}}, {16{1'b1}}};
      WIDTH_32: m = {{32{1'b0}}, {32{1'b1}}};
      WIDTH_64: m = {64{1'b1}};
    endcase
    return m;
  endfunction : lane_mask

  // Register file and per-bank machine state
  logic [31:0] ctrl_reg [NUM_BANKS];
  logic [31:0] cfg_q [NUM_BANKS];
  rbc_state_t st_reg [NUM_BANKS];
  logic [5:0] cnt_reg [NUM_BANKS];
  logic [1:0] dcnt_reg [NUM_BANKS];
  logic [3:0] hcnt_reg [NUM_BANKS];
  logic [NUM_BANKS-1:0] wr_q;
  logic [NUM_BANKS-1:0] active;
  logic [NUM_BANKS-1:0] start;
  logic [NUM_BANKS-1:0] cap;
  logic [NUM_BANKS-1:0] done_b;
  logic [NUM_BANKS-1:0] sel_bank;
  logic strap_done_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] be_mask;
  logic [31:0] status_word;
  logic [31:0] rd_val;
  logic sel_status;
  logic sel_any;
  logic [1:0] sel_idx;
  logic bus_req;
  logic bus_wr_take;
  logic busy_any;
  logic take;
  logic hit;
  logic [1:0] tgt_idx;
  logic [31:0] tgt_ctrl;
  logic tgt_port;
  logic [1:0] tgt_width;
  logic [1:0] act_bank_reg;
  logic [31:0] act_cfg;
  logic [WIDE_W-1:0] rd_src;
  logic acc_done_reg;
  logic acc_error_reg;
  logic [WIDE_W-1:0] acc_rdata_reg;
  logic [31:0] mem_addr_reg;
  logic [WIDE_W-1:0] wide_out_reg;
  logic wide_oe_reg;
  logic [NARROW_W-1:0] narrow_out_reg;
  logic narrow_oe_reg;

  // Avalon slave decode: one wait cycle, then the answer
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_reg;
  assign bus_wr_take = avs_write & ack_reg;
  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign sel_status = (avs_address == STATUS_OFS);
  assign sel_any = |sel_bank;
  assign sel_idx = avs_address[BANK_IDX_LSB+:2];
  assign status_word = {27'h0, strap_done_reg, active};
  assign rd_val = sel_status ? status_word :
                  sel_any ? ctrl_reg[sel_idx] : 32'h00000000;
  assign avs_readdata = rdata_reg;

  // Bus handshake and read data capture
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
      if (avs_read & ~ack_reg) begin
        rdata_reg <= rd_val;
      end
    end
  end

  // Strap capture flag, set on the first edge after reset release
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_done_reg <= 1'b0;
    end else begin
      strap_done_reg <= 1'b1;
    end
  end

  // Access request decode against the memory window
  assign busy_any = |active;
  assign acc_ready = ~busy_any;
  assign take = acc_req & acc_ready;
  assign hit = (acc_addr[WINDOW_LSB+:8] == ROM_WINDOW);
  assign tgt_idx = acc_addr[BANK_SEL_LSB+:2];
  assign tgt_ctrl = ctrl_reg[tgt_idx];
  assign tgt_port = tgt_ctrl[PORT_BIT];
  assign tgt_width = tgt_ctrl[WIDTH_LSB+:2];
  assign act_cfg = cfg_q[act_bank_reg];
  assign rd_src = act_cfg[PORT_BIT] ? wide_data_in :
                  {{(WIDE_W-NARROW_W){1'b0}}, narrow_data_in};

  // One machine, control register and decode per bank
  genvar g;
  generate
    for (g = 0; g < NUM_BANKS; g++) begin : g_bank
      logic bm;
      logic flash_write_permit;
      logic [1:0] select_assert_delay;
      logic [1:0] output_enable_assert_delay;
      logic [1:0] write_strobe_assert_delay;
      logic write_strobe_early_release;
      logic re;
      logic are;
      logic wr;
      logic [5:0] wait_len;
      logic [3:0] hold_len;
      logic last;
      logic fin;
      logic to_idle;
      logic on;
      logic strobing;
      logic cs_on;
      logic oe_on;
      logic we_on;
      logic [5:0] oe_at;
      logic [5:0] we_at;
      rbc_state_t after_st;

      // Fields of the frozen copy taken at access start
      assign bm = cfg_q[g][BM_BIT];
      assign flash_write_permit = cfg_q[g][FWE_BIT];
      assign select_assert_delay = cfg_q[g][SELECT_ASSERT_DELAY_LSB+:2];
      assign output_enable_assert_delay = cfg_q[g][OUTPUT_ENABLE_ASSERT_DELAY_LSB+:2];
      assign write_strobe_assert_delay = cfg_q[g][WRITE_STROBE_ASSERT_DELAY_LSB+:2];
      assign write_strobe_early_release = cfg_q[g][WRITE_STROBE_EARLY_RELEASE_BIT];
      assign re = cfg_q[g][RE_BIT];
      assign are = cfg_q[g][ARE_BIT];
      assign wr = wr_q[g];

      // Strobe length and hold length for this access
      assign wait_len = bm ? {2'b00, cfg_q[g][FWT_LSB+:4]} :
                        cfg_q[g][WAIT_LSB+:6];
      assign hold_len = wr ? cfg_q[g][WRITE_HOLD_CYCLES_LSB+:4] :
                        cfg_q[g][READ_HOLD_CYCLES_LSB+:4];
      assign last = (st_reg[g] == ST_STROBE) && (cnt_reg[g] == wait_len);
      assign fin = (last & ~re) |
                   ((st_reg[g] == ST_SAMPLE_DLY) &&
                    (dcnt_reg[g] == SYNC_RDY_DLY));
      assign to_idle = (fin && (hold_len == 4'h0)) |
                       ((st_reg[g] == ST_HOLD) && (hcnt_reg[g] == 4'h1));
      assign after_st = (hold_len == 4'h0) ? ST_IDLE : ST_HOLD;

      // Strobe timing measured from address valid
      assign on = (st_reg[g] != ST_IDLE);
      assign strobing = (st_reg[g] == ST_STROBE);
      assign oe_at = 6'(select_assert_delay) + 6'(output_enable_assert_delay);
      assign we_at = 6'(select_assert_delay) + 6'(write_strobe_assert_delay);
      assign cs_on = on & (~strobing | (cnt_reg[g] >= 6'(select_assert_delay)));
      assign oe_on = on & ~wr & (~strobing | (cnt_reg[g] >= oe_at));
      assign we_on = on & wr & flash_write_permit & (~strobing | (cnt_reg[g] >= we_at)) &
                     ~(write_strobe_early_release & to_idle);

      // Bank pins, active low strobes
      assign bank_sel_n[g] = ~cs_on;
      assign bank_oe_n[g] = ~oe_on;
      assign bank_we_n[g] = ~we_on;
      assign bank_read[g] = on & ~wr;
      assign bank_write[g] = on & wr;
      assign active[g] = on;
      assign cap[g] = fin & ~wr;
      assign done_b[g] = to_idle;
      assign start[g] = take & hit & (tgt_idx == 2'(g));
      assign sel_bank[g] = (avs_address == BANK_OFS[g]);

      // Control register with byte enables; bank 0 loads straps
      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          ctrl_reg[g] <= (g == 0) ? CTRL0_RST : CTRL_RST;
        end else begin
          if (bus_wr_take && sel_bank[g]) begin
            ctrl_reg[g] <= (ctrl_reg[g] & ~be_mask) |
                           (avs_writedata & be_mask);
          end else if ((g == 0) && !strap_done_reg) begin
            ctrl_reg[g][PORT_BIT] <= strap_shared_port;
            ctrl_reg[g][RE_BIT] <= strap_throttle;
            ctrl_reg[g][WIDTH_LSB+:2] <= strap_width;
          end
        end
      end

      // Chip select machine
      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          st_reg[g] <= ST_IDLE;
          cnt_reg[g] <= 6'h00;
          dcnt_reg[g] <= 2'h0;
          hcnt_reg[g] <= 4'h0;
          cfg_q[g] <= (g == 0) ? CTRL0_RST : CTRL_RST;
          wr_q[g] <= 1'b0;
        end else begin
          unique case (st_reg[g])
            ST_IDLE: begin
              if (start[g]) begin
                st_reg[g] <= ST_STROBE;
                cnt_reg[g] <= 6'h00;
                cfg_q[g] <= ctrl_reg[g];
                wr_q[g] <= acc_write;
              end
            end
            ST_STROBE: begin
              if (last && re) begin
                st_reg[g] <= ST_READY_WAIT;
              end else if (last) begin
                st_reg[g] <= after_st;
                hcnt_reg[g] <= hold_len;
              end else begin
                cnt_reg[g] <= cnt_reg[g] + 6'h01;
              end
            end
            ST_READY_WAIT: begin
              if (mem_ready) begin
                st_reg[g] <= ST_SAMPLE_DLY;
                dcnt_reg[g] <= are ? ASYNC_RDY_DLY : SYNC_RDY_DLY;
              end
            end
            ST_SAMPLE_DLY: begin
              if (dcnt_reg[g] == SYNC_RDY_DLY) begin
                st_reg[g] <= after_st;
                hcnt_reg[g] <= hold_len;
              end else begin
                dcnt_reg[g] <= dcnt_reg[g] - 2'h1;
              end
            end
            ST_HOLD: begin
              if (hcnt_reg[g] == 4'h1) begin
                st_reg[g] <= ST_IDLE;
              end else begin
                hcnt_reg[g] <= hcnt_reg[g] - 4'h1;
              end
            end
            default: begin
              st_reg[g] <= ST_IDLE;
            end
          endcase
        end
      end
    end
  endgenerate

  // Access bookkeeping, address latch and data lanes
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      act_bank_reg <= 2'h0;
      mem_addr_reg <= 32'h00000000;
      acc_done_reg <= 1'b0;
      acc_error_reg <= 1'b0;
      acc_rdata_reg <= '0;
    end else begin
      acc_done_reg <= (|done_b) | (take & ~hit);
      acc_error_reg <= take & ~hit;
      if (take && hit) begin
        act_bank_reg <= tgt_idx;
        mem_addr_reg <= acc_addr;
      end
      if (|cap) begin
        acc_rdata_reg <= rd_src & lane_mask(act_cfg[WIDTH_LSB+:2]);
      end
    end
  end

  // Write data drive toward the selected data port
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wide_out_reg <= '0;
      wide_oe_reg <= 1'b0;
      narrow_out_reg <= '0;
      narrow_oe_reg <= 1'b0;
    end else begin
      if (take && hit && acc_write) begin
        wide_out_reg <= acc_wdata & lane_mask(tgt_width);
        narrow_out_reg <= acc_wdata[NARROW_W-1:0];
        wide_oe_reg <= tgt_port;
        narrow_oe_reg <= ~tgt_port;
      end else if (|done_b) begin
        wide_oe_reg <= 1'b0;
        narrow_oe_reg <= 1'b0;
      end
    end
  end

  // Output drive
  assign acc_done = acc_done_reg;
  assign acc_error = acc_error_reg;
  assign acc_rdata = acc_rdata_reg;
  assign mem_addr = mem_addr_reg;
  assign wide_data_out = wide_out_reg;
  assign wide_data_oe = wide_oe_reg;
  assign narrow_data_out = narrow_out_reg;
  assign narrow_data_oe = narrow_oe_reg;

endmodule : rbc_bank_ctrl

`default_nettype wire

//--- src/rbc_pkg.sv
// Constants, field layout and state codes for the ROM bank controller
package rbc_pkg;

  // Bank count and bus widths
  localparam int NUM_BANKS = 4;
  localparam int AV_ADDR_W = 8;
  localparam int WIDE_W = 64;
  localparam int NARROW_W = 8;

  // Register byte offsets
  localparam logic [7:0] STATUS_OFS = 8'h80;
  localparam logic [7:0] BANK0_OFS = 8'h88;
  localparam logic [7:0] BANK1_OFS = 8'h98;
  localparam logic [7:0] BANK2_OFS = 8'hA8;
  localparam logic [7:0] BANK3_OFS = 8'hB8;
  localparam logic [7:0] BANK_OFS [NUM_BANKS] = '{
    BANK0_OFS, BANK1_OFS, BANK2_OFS, BANK3_OFS
  };
  localparam int BANK_IDX_LSB = 4;

  // Control field positions (bit 31 is the leftmost field)
  localparam int BM_BIT = 31;
  localparam int FWE_BIT = 30;
  localparam int WAIT_LSB = 24;
  localparam int SELECT_ASSERT_DELAY_LSB = 22;
  localparam int OUTPUT_ENABLE_ASSERT_DELAY_LSB = 20;
  localparam int WRITE_STROBE_ASSERT_DELAY_LSB = 18;
  localparam int PORT_BIT = 17;
  localparam int WRITE_STROBE_EARLY_RELEASE_BIT = 16;
  localparam int READ_HOLD_CYCLES_LSB = 12;
  localparam int WRITE_HOLD_CYCLES_LSB = 8;
  localparam int FWT_LSB = 4;
  localparam int RE_BIT = 3;
  localparam int ARE_BIT = 2;
  localparam int WIDTH_LSB = 0;

  // Reset values: bank 0 boots with slow strobes, others all zero
  localparam logic [31:0] CTRL0_RST = 32'h146544B0;
  localparam logic [31:0] CTRL_RST = 32'h00000000;

  // Status register layout
  localparam int STAT_BUSY_LSB = 0;
  localparam int STAT_STRAP_BIT = 4;

  // Bank width codes
  localparam logic [1:0] WIDTH_8 = 2'b00;
  localparam logic [1:0] WIDTH_16 = 2'b01;
  localparam logic [1:0] WIDTH_32 = 2'b10;
  localparam logic [1:0] WIDTH_64 = 2'b11;

  // Ready-to-data sampling delays in clocks
  localparam logic [1:0] SYNC_RDY_DLY = 2'h1;
  localparam logic [1:0] ASYNC_RDY_DLY = 2'h3;

  // Memory window decode: top byte selects window, next two bits bank
  localparam logic [7:0] ROM_WINDOW = 8'hFF;
  localparam int WINDOW_LSB = 24;
  localparam int BANK_SEL_LSB = 22;

  // Per-bank chip select machine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_STROBE = 3'b001,
    ST_READY_WAIT = 3'b010,
    ST_SAMPLE_DLY = 3'b011,
    ST_HOLD = 3'b100
  } rbc_state_t;

endpackage : rbc_pkg

//--- verif/rbc_bank_ctrl_asserts.sv
// Concurrent checks on the ROM bank controller ports
`timescale 1ns/1ps
`default_nettype none

module rbc_chk (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic avs_read,
  input wire logic avs_waitrequest,
  input wire logic acc_ready,
  input wire logic acc_done,
  input wire logic acc_error,
  input wire logic [rbc_pkg::NUM_BANKS-1:0] bank_sel_n,
  input wire logic [rbc_pkg::NUM_BANKS-1:0] bank_oe_n,
  input wire logic [rbc_pkg::NUM_BANKS-1:0] bank_we_n,
  input wire logic [rbc_pkg::NUM_BANKS-1:0] bank_read,
  input wire logic [rbc_pkg::NUM_BANKS-1:0] bank_write,
  input wire logic wide_data_oe,
  input wire logic narrow_data_oe
);
  import rbc_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Register bus and access sequencing
  bus_wait_a: assert property (
    $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read not answered after one wait cycle");
  sel_onehot_a: assert property ($onehot0(~bank_sel_n))
    else $error("two bank selects active together");
  sel_delay_a: assert property (
    $rose(|(bank_read | bank_write)) |-> ##[0:3] (bank_sel_n != 4'hF))
    else $error("bank select late after address");
  oe_sel_a: assert property ((~bank_oe_n & bank_sel_n) == 4'h0)
    else $error("output enable without bank select");
  oe_read_a: assert property ((~bank_oe_n & ~bank_read) == 4'h0)
    else $error("output enable outside a read");
  we_write_a: assert property ((~bank_we_n & ~bank_write) == 4'h0)
    else $error("write strobe outside a write");
  err_done_a: assert property (
    acc_error |-> acc_done && (bank_sel_n == 4'hF))
    else $error("error without done or with strobes");
  busy_ready_a: assert property (
    |(bank_read | bank_write) |-> !acc_ready)
    else $error("new access accepted while bank busy");
  // Write data drive on exactly one port, only during a write
  wr_port_a: assert property (
    $rose(|bank_write) |-> (wide_data_oe ^ narrow_data_oe))
    else $error("write data not driven on one port");
  oe_write_a: assert property (
    (wide_data_oe | narrow_data_oe) |-> |bank_write)
    else $error("data port driven outside a write");
endmodule : rbc_chk

bind rbc_bank_ctrl rbc_chk u_chk (.core_clk, .sys_rst, .avs_read,
  .avs_waitrequest, .acc_ready, .acc_done, .acc_error, .bank_sel_n,
  .bank_oe_n, .bank_we_n, .bank_read, .bank_write, .wide_data_oe,
  .narrow_data_oe);

`default_nettype wire

//--- verif/rbc_mem_model.sv
// Behavioural memory device answering the bank strobes
`timescale 1ns/1ps
`default_nettype none

module rbc_mem_model #(
  parameter int RDY = 6,
  parameter logic [55:0] WORD_HI = 56'h11223344556677
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [rbc_pkg::NUM_BANKS-1:0] bank_read,
  input wire logic [rbc_pkg::NUM_BANKS-1:0] bank_oe_n,
  output logic mem_ready,
  output logic [rbc_pkg::WIDE_W-1:0] wide_data_in,
  output logic [rbc_pkg::NARROW_W-1:0] narrow_data_in
);
  import rbc_pkg::*;
  logic [7:0] cnt_reg;
  logic drive;
  // Cycles since the access began, so sampled data tells the edge
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) cnt_reg <= 8'h00;
    else if (|bank_read) cnt_reg <= cnt_reg + 8'h01;
    else cnt_reg <= 8'h00;
  end
  // Ready only after RDY cycles; released lines show the inverse
  assign mem_ready = (cnt_reg >= 8'(RDY));
  assign drive = ~&bank_oe_n;
  assign wide_data_in = drive ? {WORD_HI, cnt_reg} : ~{WORD_HI, cnt_reg};
  assign narrow_data_in = drive ? cnt_reg : ~cnt_reg;
endmodule : rbc_mem_model

`default_nettype wire

//--- verif/testbench.sv
// Self-checking testbench for the ROM bank controller
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import rbc_pkg::*;
  localparam int RDY = 6;
  localparam logic [55:0] WORD_HI = 56'h11223344556677;
  logic core_clk, sys_rst, avs_read, avs_write, acc_req, acc_write;
  logic [7:0] avs_address, narrow_data_in, narrow_data_out;
  logic [31:0] avs_writedata, avs_readdata, acc_addr, mem_addr, rd;
  logic avs_waitrequest, acc_ready, acc_done, acc_error, mem_ready, err;
  logic [63:0] acc_wdata, acc_rdata, wide_data_in, wide_data_out, rdat;
  logic [3:0] bank_sel_n, bank_oe_n, bank_we_n, bank_read, bank_write;
  logic wide_data_oe, narrow_data_oe;
  int bad_count, n_tests, ncyc;

  rbc_bank_ctrl DUT (.core_clk, .sys_rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
    .avs_waitrequest, .strap_shared_port(1'b1), .strap_throttle(1'b1),
    .strap_width(2'b10), .acc_req, .acc_write, .acc_addr, .acc_wdata,
    .acc_ready, .acc_done, .acc_error, .acc_rdata, .mem_addr, .bank_sel_n,
    .bank_oe_n, .bank_we_n, .bank_read, .bank_write, .mem_ready,
    .wide_data_in, .wide_data_out, .wide_data_oe, .narrow_data_in,
    .narrow_data_out, .narrow_data_oe);
  rbc_mem_model #(.RDY(RDY), .WORD_HI(WORD_HI)) u_mem (.core_clk, .sys_rst,
    .bank_read, .bank_oe_n, .mem_ready, .wide_data_in, .narrow_data_in);

  // 125 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic hang();
    bad_count++;
    $display("unexpected at %0t: wait ran out", $time);
    report_and_stop();
  endtask : hang

  // One register bus cycle, held until waitrequest is seen low
  task automatic av(input logic wr, input logic [7:0] a,
                    input logic [31:0] d);
    int i;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 50);
    if (i >= 50) hang();
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : av

  // One memory access; ncyc counts cycles from take to done
  task automatic acc(input logic wr, input logic [31:0] a);
    int i;
    i = 0;
    while (acc_ready !== 1'b1 && i < 200) begin
      @(posedge core_clk);
      #1;
      i++;
    end
    if (i >= 200) hang();
    @(posedge core_clk);
    acc_req <= 1'b1;
    acc_write <= wr;
    acc_addr <= a;
    @(posedge core_clk);
    acc_req <= 1'b0;
    #1;
    ncyc = 0;
    while (acc_done !== 1'b1 && ncyc < 300) begin
      @(posedge core_clk);
      #1;
      ncyc++;
    end
    if (ncyc >= 300) hang();
    rdat = acc_rdata;
    err = acc_error;
  endtask : acc

  // Reset values, read-only status and unmapped offsets
  task automatic t_reset();
    av(0, BANK0_OFS, 32'h0);
    chk(64'(rd), 64'h146744BA);
    chk(64'(rd[3:0]), 64'hA);
    for (int b = 1; b < 4; b++) begin
      av(0, BANK_OFS[b], 32'h0);
      chk(64'(rd), 64'h0);
    end
    av(1, STATUS_OFS, 32'hFFFFFFFF);
    av(0, STATUS_OFS, 32'h0);
    chk(64'(rd), 64'h10);
    av(1, 8'h90, 32'hFFFFFFFF);
    av(0, 8'h90, 32'h0);
    chk(64'(rd), 64'h0);
  endtask : t_reset

  // Every width on the wide bus, ready ignored, hold counted
  task automatic t_width();
    logic [63:0] m;
    for (int w = 0; w < 4; w++) begin
      av(1, BANK1_OFS, 32'h03922000 | 32'(w));
      av(0, BANK1_OFS, 32'h0);
      chk(64'(rd), 64'(32'h03922000 | 32'(w)));
      acc(0, 32'hFF400000);
      m = (w == 3) ? '1 : (64'h1 << (8 << w)) - 64'h1;
      chk(rdat, {WORD_HI, 8'h03} & m);
      chk(64'(ncyc), 64'd6);
    end
    // Burst mode: first burst wait sets the strobe length
    av(1, BANK1_OFS, 32'h83920041);
    acc(0, 32'hFF400000);
    chk(rdat, {WORD_HI, 8'h04} & 64'hFFFF);
    chk(64'(ncyc), 64'd5);
    av(1, BANK1_OFS, 32'h43920201);
    acc(1, 32'hFF400010);
    chk(64'(ncyc), 64'd6);
    chk(64'({err, mem_addr}), 64'hFF400010);
    chk(wide_data_out, acc_wdata & 64'hFFFF);
    chk(64'(narrow_data_out), 64'(acc_wdata[7:0]));
  endtask : t_width

  // Throttled narrow bank: synchronous then asynchronous ready
  task automatic t_ready();
    for (int k = 0; k < 2; k++) begin
      av(1, BANK2_OFS, 32'h01000008 | 32'(k << 2));
      acc(0, 32'hFF800000);
      chk(rdat, 64'(RDY + 1 + 2 * k));
      chk(64'(ncyc), 64'(RDY + 2 + 2 * k));
    end
  endtask : t_ready

  // Address outside the window ends at once with an error
  task automatic t_unmapped();
    acc(0, 32'h10000000);
    chk(64'({err, ncyc[1:0]}), 64'h4);
  endtask : t_unmapped

  initial begin
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    acc_req = 1'b0;
    acc_write = 1'b0;
    acc_addr = 32'h0;
    acc_wdata = 64'h0F0E0D0C0B0A0908;
    bad_count = 0;
    n_tests = 0;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_width();
    t_ready();
    t_unmapped();
    report_and_stop();
  end
endmodule : testbench

`default_nettype wire
